/* File: via_pkg.sv */
// Shared constants and types of the shifter and interrupt block
package via_pkg;

  localparam logic [3:0] SHIFTER_OFS = 4'hA;
  localparam logic [3:0] FLAGS_OFS = 4'hD;
  localparam logic [3:0] ENABLES_OFS = 4'hE;

  localparam int A_LINE2_BIT = 0;
  localparam int A_LINE1_BIT = 1;
  localparam int SH_FLAG_BIT = 2;
  localparam int B_LINE2_BIT = 3;
  localparam int B_LINE1_BIT = 4;
  localparam int SUMMARY_BIT = 7;
  localparam int ENABLE_SET_BIT = 7;

  localparam int CLK_HZ = 25_000_000;
  localparam int SYS_HZ = 1_000_000;
  localparam int SYS_DIV_CYCLES = CLK_HZ / SYS_HZ;

  localparam logic [3:0] BIT_LAST = 4'h7;

  localparam logic [2:0] MODE_FREE = 3'h4;
  localparam logic [2:0] MODE_GATED = 3'h5;
  localparam logic [2:0] MODE_SYS = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;

  localparam logic [7:0] SHIFTER_RST = 8'h00;
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic [6:0] ENABLES_RST = 7'h00;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic run;
    logic [6:0] flags;
    logic [6:0] ena;
    logic [7:0] half;
    logic [4:0] div;
    logic [2:0] sync;
    logic ext;
    logic clk_o;
    logic clk_oe_n;
    logic dat_o;
    logic dat_oe_n;
    logic irq_n;
    logic [7:0] rdata;
  } state_s;

  localparam state_s STATE_RST = '{
    sh: SHIFTER_RST, flags: FLAGS_RST, ena: ENABLES_RST,
    clk_o: 1'b1, clk_oe_n: 1'b1, dat_oe_n: 1'b1, irq_n: 1'b1, default: '0};

endpackage : via_pkg

/* File: via_shift_out_and_irq_logic.sv */
// Serial shift-out modes with interrupt flag and enable registers
//
// Operation
// R1: Free-running timer mode rotates byte endlessly, no counting
// R2: Gated mode: access starts now if flag set
// R3: Gated mode access resets counter, sends eight bits
// R4: After eighth pulse stop, set flag, hold data
// R5: System-clock mode toggles the shift clock every system tick, one bit per two ticks
// R6: External clock: flag every eight pulses, keep shifting
// R7: External mode access clears flag, restarts counter
// R8: Flags stay set until explicitly cleared
// R9: Interrupt requested only for enabled set flags
// R10: Flag register bit 7 shows active interrupt
// R11: Writing one clears flag; bit 7 not
// R12: Summary falls only when nothing enabled is set
// R13: Enable write, bit 7 low, clears ones
// R14: Enable write, bit 7 high, sets ones
// R15: Enable read returns bit 7 as one
// R16: Independent line flags survive port register access
// R17: Most significant bit first, rotated into bit 0
// R18: Timer latch low byte sets clock half period
// R19: System-clock access makes eight-pulse burst, then flag
`timescale 1ns/1ps
`default_nettype none

module via_shift_out_and_irq_logic #(
  parameter int DIV_CYCLES = via_pkg::SYS_DIV_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire via_pkg::bus_req_s bus_in,
  output logic [7:0] rdata_out,
  input wire logic [2:0] shifter_mode_select_in,
  input wire logic [7:0] second_timer_latch_lo_in,
  input wire logic [6:0] flag_set_in,
  input wire logic port_a_access_in,
  input wire logic port_b_access_in,
  input wire logic [1:0] line2_independent_in,
  input wire logic port_b_ctrl_line_1_in,
  output logic port_b_ctrl_line_1_out,
  output logic port_b_ctrl_line_1_oe_n_out,
  output logic port_b_ctrl_line_2_out,
  output logic port_b_ctrl_line_2_oe_n_out,
  output logic irq_n_out
);

  if (DIV_CYCLES < 1 || DIV_CYCLES > 32) begin : g_div_check
    $error("DIV_CYCLES must lie in 1..32");
  end

  localparam logic [4:0] DIV_LAST = 5'(DIV_CYCLES - 1);

  via_pkg::state_s r_reg;
  via_pkg::state_s r_next;

  logic tick;
  logic pace;
  logic timed;
  logic internal;
  logic out_mode;
  logic ext_rise;
  logic ext_fall;
  logic sh_acc;
  logic sh_set;
  logic flag_wr;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic [2:0] mode;

  assign mode = shifter_mode_select_in;

  always_comb begin
    r_next = r_reg;
    // One-cycle enable at the 1 MHz system rate
    tick = (r_reg.div == DIV_LAST);
    r_next.div = tick ? 5'h00 : r_reg.div + 5'h01;

    // Only the agreeing second and third stages are looked at
    r_next.sync = {r_reg.sync[1:0], port_b_ctrl_line_1_in};
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    if (r_reg.sync[1] == r_reg.sync[2] && r_reg.sync[2] != r_reg.ext) begin
      r_next.ext = r_reg.sync[2];
      ext_rise = r_reg.sync[2];
      ext_fall = !r_reg.sync[2];
    end

    sh_acc = bus_in.sel && (bus_in.rd || bus_in.wr) && bus_in.addr == via_pkg::SHIFTER_OFS;
    flag_wr = bus_in.sel && bus_in.wr && bus_in.addr == via_pkg::FLAGS_OFS;
    sh_set = 1'b0;

    out_mode = mode[2];
    timed = (mode == via_pkg::MODE_FREE) || (mode == via_pkg::MODE_GATED);
    internal = out_mode && (mode != via_pkg::MODE_EXT);
    r_next.clk_oe_n = !internal;
    r_next.dat_oe_n = !out_mode;

    // Half-period timer reloaded from the latch low byte
    pace = 1'b0;
    if (timed && tick) begin
      if (r_reg.half == 8'h00) begin
        r_next.half = second_timer_latch_lo_in; // [R18]
        pace = 1'b1;
      end else begin
        r_next.half = r_reg.half - 8'h01;
      end
    end
    if (mode == via_pkg::MODE_SYS) begin
      pace = tick; // [R5]
    end

    if (internal && pace && (mode == via_pkg::MODE_FREE || r_reg.run)) begin
      if (r_reg.clk_o) begin
        // Falling edge presents the top bit and rotates it round
        r_next.clk_o = 1'b0;
        r_next.dat_o = r_reg.sh[7]; // [R17]
        r_next.sh = {r_reg.sh[6:0], r_reg.sh[7]}; // [R1] [R17]
      end else begin
        r_next.clk_o = 1'b1;
        if (mode != via_pkg::MODE_FREE) begin
          r_next.cnt = r_reg.cnt + 4'h1; // [R3]
          if (r_reg.cnt == via_pkg::BIT_LAST) begin
            // Data output keeps the last bit sent
            r_next.run = 1'b0; // [R4] [R19]
            sh_set = 1'b1; // [R4] [R19]
          end
        end
      end
    end
    if (!internal) begin
      r_next.clk_o = 1'b1;
    end

    if (mode == via_pkg::MODE_EXT) begin
      if (ext_fall) begin
        r_next.dat_o = r_reg.sh[7]; // [R17]
        r_next.sh = {r_reg.sh[6:0], r_reg.sh[7]};
      end
      if (ext_rise) begin
        // Pulse counter only; shifting never stops here
        if (r_reg.cnt == via_pkg::BIT_LAST) begin
          r_next.cnt = 4'h0;
          sh_set = 1'b1; // [R6]
        end else begin
          r_next.cnt = r_reg.cnt + 4'h1; // [R6]
        end
      end
    end

    if (sh_acc) begin
      r_next.cnt = 4'h0; // [R3] [R7]
      r_next.run = (mode == via_pkg::MODE_GATED) || (mode == via_pkg::MODE_SYS); // [R3] [R19]
      if (mode == via_pkg::MODE_GATED && r_reg.flags[via_pkg::SH_FLAG_BIT]) begin
        r_next.half = 8'h00; // [R2]
      end
      if (bus_in.wr) begin
        r_next.sh = bus_in.wdata;
      end
    end

    set_v = flag_set_in;
    set_v[via_pkg::SH_FLAG_BIT] = sh_set;
    clr_v = 7'h00;
    clr_v[via_pkg::SH_FLAG_BIT] = sh_acc; // [R7]
    if (flag_wr) begin
      clr_v = clr_v | bus_in.wdata[6:0]; // [R11]
    end
    if (port_a_access_in) begin
      clr_v[via_pkg::A_LINE1_BIT] = 1'b1;
      if (!line2_independent_in[0]) begin
        clr_v[via_pkg::A_LINE2_BIT] = 1'b1; // [R16]
      end
    end
    if (port_b_access_in) begin
      clr_v[via_pkg::B_LINE1_BIT] = 1'b1;
      if (!line2_independent_in[1]) begin
        clr_v[via_pkg::B_LINE2_BIT] = 1'b1; // [R16]
      end
    end
    // A set arriving with its clear is kept
    r_next.flags = (r_reg.flags & ~clr_v) | set_v; // [R8]

    if (bus_in.sel && bus_in.wr && bus_in.addr == via_pkg::ENABLES_OFS) begin
      if (bus_in.wdata[via_pkg::ENABLE_SET_BIT]) begin
        r_next.ena = r_reg.ena | bus_in.wdata[6:0]; // [R14]
      end else begin
        r_next.ena = r_reg.ena & ~bus_in.wdata[6:0]; // [R13]
      end
    end

    r_next.irq_n = !(|(r_next.flags & r_next.ena)); // [R9] [R12]

    if (bus_in.sel && bus_in.rd) begin
      case (bus_in.addr)
        via_pkg::SHIFTER_OFS: r_next.rdata = r_reg.sh;
        via_pkg::FLAGS_OFS: r_next.rdata = {|(r_reg.flags & r_reg.ena), r_reg.flags}; // [R10]
        via_pkg::ENABLES_OFS: r_next.rdata = {1'b1, r_reg.ena}; // [R15]
        default: r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_reg <= via_pkg::STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata_out = r_reg.rdata;
  assign port_b_ctrl_line_1_out = r_reg.clk_o;
  assign port_b_ctrl_line_1_oe_n_out = r_reg.clk_oe_n;
  assign port_b_ctrl_line_2_out = r_reg.dat_o;
  assign port_b_ctrl_line_2_oe_n_out = r_reg.dat_oe_n;
  assign irq_n_out = r_reg.irq_n;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_sys_start;
    sh_acc && mode == via_pkg::MODE_SYS;
  endsequence

  sequence s_burst_end;
    ##[1:600] (r_reg.flags[via_pkg::SH_FLAG_BIT] && !r_reg.run);
  endsequence

  a_free_no_count: assert property (mode == via_pkg::MODE_FREE && !sh_acc |=> r_reg.cnt == $past(r_reg.cnt)) // [R1]
    else $error("counter moved in free-running mode");

  a_gated_fast_start: assert property (sh_acc && mode == via_pkg::MODE_GATED
    && r_reg.flags[via_pkg::SH_FLAG_BIT] |=> r_reg.half == 8'h00) // [R2]
    else $error("gated start not immediate");

  a_gated_restart: assert property (sh_acc && mode == via_pkg::MODE_GATED |=> r_reg.run && r_reg.cnt == 4'h0) // [R3]
    else $error("gated access did not restart burst");

  a_gated_stop: assert property ($rose(r_reg.flags[via_pkg::SH_FLAG_BIT]) && mode == via_pkg::MODE_GATED
    && !$past(sh_acc) |-> !r_reg.run) // [R4]
    else $error("shifting continued after flag");

  a_sys_burst: assert property (s_sys_start |-> s_burst_end) // [R19]
    else $error("system clock burst did not finish");

  a_ext_flag_set: assert property (mode == via_pkg::MODE_EXT && ext_rise && r_reg.cnt == via_pkg::BIT_LAST
    |=> r_reg.flags[via_pkg::SH_FLAG_BIT] && r_reg.cnt == 4'h0) // [R6]
    else $error("eighth external pulse missed");

  a_ext_access: assert property (sh_acc && mode == via_pkg::MODE_EXT && !sh_set
    |=> !r_reg.flags[via_pkg::SH_FLAG_BIT] && r_reg.cnt == 4'h0) // [R7]
    else $error("external access did not clear");

  a_flag_sticky: assert property (1'b1 |=> ($past(r_reg.flags) & ~$past(clr_v) & ~r_reg.flags) == 7'h00) // [R8]
    else $error("flag dropped without clear");

  a_irq_level: assert property (irq_n_out == !(|(r_reg.flags & r_reg.ena))) // [R9]
    else $error("interrupt output disagrees with flags");

  a_summary_read: assert property (bus_in.sel && bus_in.rd && bus_in.addr == via_pkg::FLAGS_OFS
    |=> rdata_out == {|$past(r_reg.flags & r_reg.ena), $past(r_reg.flags)}) // [R10]
    else $error("flag register read wrong");

  a_flag_wr_clear: assert property (flag_wr |=> (r_reg.flags & $past(bus_in.wdata[6:0]) & ~$past(set_v)) == 7'h00) // [R11]
    else $error("flag write did not clear");

  a_enable_clear: assert property (bus_in.sel && bus_in.wr && bus_in.addr == via_pkg::ENABLES_OFS
    && !bus_in.wdata[7] |=> (r_reg.ena & $past(bus_in.wdata[6:0])) == 7'h00) // [R13]
    else $error("enable bits not cleared");

  a_enable_set: assert property (bus_in.sel && bus_in.wr && bus_in.addr == via_pkg::ENABLES_OFS
    && bus_in.wdata[7] |=> (r_reg.ena & $past(bus_in.wdata[6:0])) == $past(bus_in.wdata[6:0])) // [R14]
    else $error("enable bits not set");

  a_enable_read: assert property (bus_in.sel && bus_in.rd && bus_in.addr == via_pkg::ENABLES_OFS
    |=> rdata_out == {1'b1, $past(r_reg.ena)}) // [R15]
    else $error("enable register read wrong");

  a_line2_keep: assert property (port_b_access_in && line2_independent_in[1] && !flag_wr
    && r_reg.flags[via_pkg::B_LINE2_BIT] |=> r_reg.flags[via_pkg::B_LINE2_BIT]) // [R16]
    else $error("independent flag cleared by port access");

  a_msb_out: assert property ($fell(r_reg.clk_o) |-> r_reg.dat_o == $past(r_reg.sh[7])) // [R17]
    else $error("bit presented out of order");

  a_ext_clk_released: assert property (mode == via_pkg::MODE_EXT |=> port_b_ctrl_line_1_oe_n_out) // [R6]
    else $error("shift clock driven in external mode");

  a_int_clk_driven: assert property (internal |=> !port_b_ctrl_line_1_oe_n_out) // [R5]
    else $error("shift clock not driven");

  a_data_driven: assert property (out_mode |=> !port_b_ctrl_line_2_oe_n_out) // [R17]
    else $error("serial data not driven");

  a_free_rotate: assert property (mode == via_pkg::MODE_FREE && pace && r_reg.clk_o && !sh_acc
    |=> r_reg.sh == {$past(r_reg.sh[6:0]), $past(r_reg.sh[7])}) // [R1]
    else $error("free-running byte not rotated");

  a_gated_hold_data: assert property (mode == via_pkg::MODE_GATED && !r_reg.run
    |=> $stable(port_b_ctrl_line_2_out)) // [R4]
    else $error("data moved after burst");

  a_gated_no_pulse: assert property (mode == via_pkg::MODE_GATED && !r_reg.run
    |=> $stable(r_reg.clk_o)) // [R4]
    else $error("clock pulse after burst");

  a_sys_toggle: assert property (mode == via_pkg::MODE_SYS && tick && r_reg.run
    |=> r_reg.clk_o != $past(r_reg.clk_o)) // [R5]
    else $error("system clock pace missed");

  a_ext_keeps_shift: assert property (mode == via_pkg::MODE_EXT && ext_fall && !sh_acc
    |=> r_reg.sh == {$past(r_reg.sh[6:0]), $past(r_reg.sh[7])}) // [R6]
    else $error("external edge did not shift");

  a_ena_others_kept: assert property (bus_in.sel && bus_in.wr && bus_in.addr == via_pkg::ENABLES_OFS
    |=> ((r_reg.ena ^ $past(r_reg.ena)) & ~$past(bus_in.wdata[6:0])) == 7'h00) // [R13]
    else $error("unselected enable bit changed");

  a_summary_low: assert property (bus_in.sel && bus_in.rd && bus_in.addr == via_pkg::FLAGS_OFS
    && !(|(r_reg.flags & r_reg.ena)) |=> !rdata_out[7]) // [R12]
    else $error("summary bit high with nothing active");

  a_flag_input_set: assert property (flag_set_in[5] |=> r_reg.flags[5]) // [R8]
    else $error("input flag not set");

  a_sh_flag_owned: assert property (!sh_set |=> !$rose(r_reg.flags[via_pkg::SH_FLAG_BIT])) // [R6]
    else $error("shifter flag set without event");

  a_shifter_read: assert property (bus_in.sel && bus_in.rd && bus_in.addr == via_pkg::SHIFTER_OFS
    |=> rdata_out == $past(r_reg.sh)) // [R7]
    else $error("shifter read wrong");

  a_port_b_clear: assert property (port_b_access_in && !flag_set_in[via_pkg::B_LINE1_BIT]
    |=> !r_reg.flags[via_pkg::B_LINE1_BIT]) // [R16]
    else $error("port access kept line flag");

  a_unmapped_read: assert property (bus_in.sel && bus_in.rd && bus_in.addr == 4'h0
    |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");

endmodule : via_shift_out_and_irq_logic

`default_nettype wire

/* File: via_ext_dev.sv */
// Outside serial device: clocks the shifter and captures its data
`timescale 1ns/1ps
`default_nettype none
module via_ext_dev (
  input wire logic go_in,
  input wire logic [3:0] n_in,
  input wire logic dat_in,
  output logic clk_out,
  output logic [7:0] rx_out
);
  initial begin
    clk_out = 1'b1;
    rx_out = 8'h00;
  end
  // Long low phase so the synced data settles before our sampling rise
  always @(posedge go_in) begin
    // Edges kept clear of the block's clock edges
    #10;
    repeat (n_in) begin
      #80 clk_out = 1'b0;
      #240 clk_out = 1'b1;
      rx_out = {rx_out[6:0], dat_in};
    end
  end
endmodule : via_ext_dev
`default_nettype wire

/* File: via_shift_out_and_irq_logic_test.sv */
// Self-checking bench of the shifter and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module via_shift_out_and_irq_logic_test;
  localparam int DIV = 2;
  localparam int L = 2;
  localparam logic [3:0] SH = via_pkg::SHIFTER_OFS;
  localparam logic [3:0] FL = via_pkg::FLAGS_OFS;
  localparam logic [3:0] EN = via_pkg::ENABLES_OFS;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  via_pkg::bus_req_s bus = '0;
  logic [2:0] mode = 3'h0;
  logic [6:0] fset = 7'h00;
  logic pa_acc = 1'b0;
  logic [1:0] indep = 2'h0;
  logic [7:0] rdata, rx;
  logic l1_o, l1_oe_n, l2_o, l2_oe_n, irq_n, ext_clk, go = 1'b0;
  logic [3:0] npulse = 4'h0;
  logic [7:0] cap = 8'h00;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt = 0;
  longint t_f = 0;
  // Pin level resolved from both parties
  wire logic l1_pin = l1_oe_n ? ext_clk : l1_o;

  via_shift_out_and_irq_logic #(.DIV_CYCLES(DIV)) via_shift_out_and_irq_logic_inst (
    .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rdata_out(rdata),
    .shifter_mode_select_in(mode), .second_timer_latch_lo_in(8'(L)), .flag_set_in(fset),
    .port_a_access_in(pa_acc), .port_b_access_in(pa_acc), .line2_independent_in(indep),
    .port_b_ctrl_line_1_in(l1_pin), .port_b_ctrl_line_1_out(l1_o),
    .port_b_ctrl_line_1_oe_n_out(l1_oe_n), .port_b_ctrl_line_2_out(l2_o),
    .port_b_ctrl_line_2_oe_n_out(l2_oe_n), .irq_n_out(irq_n));
  via_ext_dev via_ext_dev_inst (.go_in(go), .n_in(npulse), .dat_in(l2_o), .clk_out(ext_clk), .rx_out(rx));

  initial forever #20 clk_in = ~clk_in;

  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("Error timeout expected end seen hang");
      end_sim();
    end
  end

  always @(negedge l1_o) t_f = $time;
  always @(posedge l1_o) begin
    cap = {cap[6:0], l2_o};
    cnt++;
    if (mode inside {3'h4, 3'h5, 3'h6}) `CHK("half", (mode == 3'h6 ? 1 : L + 1) * DIV * 40, int'($time - t_f))
  end

  task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in) bus <= '{sel: 1'b1, rd: r, wr: ~r, addr: a, wdata: d};
    @(posedge clk_in) bus <= '0;
    #1;
  endtask : acc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] ex, input string nm);
    acc(1'b1, a, 8'h00);
    `CHK(nm, ex, rdata)
  endtask : rd

  task automatic pulse(input logic [6:0] f, input logic pa);
    @(posedge clk_in) begin fset <= f; pa_acc <= pa; end
    @(posedge clk_in) begin fset <= 7'h00; pa_acc <= 1'b0; end
  endtask : pulse

  task automatic burst(input logic [2:0] m, input logic [7:0] d, input int n);
    // Free mode shifts at once, so load the byte with shifting off
    if (m == 3'h4) begin
      @(posedge clk_in) mode <= 3'h0;
      wr(SH, d);
    end
    @(posedge clk_in) mode <= m;
    cnt = 0;
    if (m != 3'h4) begin
      wr(SH, d);
    end
    for (int i = 0; i < 3000 && cnt < n; i++) @(posedge clk_in);
    // Stop the endless stream so the captured byte stays put
    if (m == 3'h4) begin
      mode <= 3'h0;
    end
    repeat (60) @(posedge clk_in);
  endtask : burst

  task automatic ext(input logic [3:0] n);
    @(posedge clk_in) begin npulse <= n; go <= 1'b1; end
    @(posedge clk_in) go <= 1'b0;
    repeat (8 * n + 10) @(posedge clk_in);
  endtask : ext

  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(FL, 8'h00, "flags");
    rd(EN, 8'h80, "enables");
    rd(4'h0, 8'h00, "unmapped");
    wr(EN, 8'h9F);
    wr(EN, 8'h03);
    rd(EN, 8'h9C, "enables");
    pulse(7'h29, 1'b0);
    rd(FL, 8'hA9, "flags");
    `CHK("irq_n", 1'b0, irq_n)
    indep <= 2'h3;
    pulse(7'h00, 1'b1);
    rd(FL, 8'hA9, "flags");
    indep <= 2'h0;
    pulse(7'h00, 1'b1);
    rd(FL, 8'h20, "flags");
    wr(EN, 8'hA0);
    rd(FL, 8'hA0, "flags");
    `CHK("irq_n", 1'b0, irq_n)
    wr(FL, 8'h80);
    rd(FL, 8'hA0, "flags");
    wr(EN, 8'h20);
    rd(FL, 8'h20, "flags");
    `CHK("irq_n", 1'b1, irq_n)
    wr(FL, 8'h20);
    rd(FL, 8'h00, "flags");
    burst(3'h6, 8'hA5, 8);
    `CHK("pulses", 8, cnt)
    `CHK("data", 8'hA5, cap)
    `CHK("line2", 1'b1, l2_o)
    `CHK("line1_oe_n", 1'b0, l1_oe_n)
    rd(FL, 8'h84, "flags");
    `CHK("irq_n", 1'b0, irq_n)
    burst(3'h5, 8'h3C, 8);
    `CHK("pulses", 8, cnt)
    `CHK("data", 8'h3C, cap)
    `CHK("line2", 1'b0, l2_o)
    rd(FL, 8'h84, "flags");
    burst(3'h4, 8'h81, 16);
    `CHK("data", 8'h81, cap)
    rd(FL, 8'h00, "flags");
    @(posedge clk_in) mode <= 3'h7;
    wr(SH, 8'hC3);
    ext(4'h8);
    `CHK("rx", 8'hC3, rx)
    rd(FL, 8'h84, "flags");
    rd(SH, 8'hC3, "shifter");
    ext(4'h4);
    rd(FL, 8'h00, "flags");
    ext(4'h4);
    rd(FL, 8'h84, "flags");
    `CHK("rx", 8'hC3, rx)
    end_sim();
  end
endmodule : via_shift_out_and_irq_logic_test
`default_nettype wire
